// file: design/uiec_defs.svh
`ifndef UIEC_DEFS_SVH
`define UIEC_DEFS_SVH
// configuration byte fields
`define UIEC_BIT_ACTIVE   7
`define UIEC_BIT_ISO      6
`define UIEC_BIT_TOGGLE   5
`define UIEC_BIT_OVERRUN  5
`define UIEC_BIT_DUAL     4
`define UIEC_BIT_STALL    3
`define UIEC_BIT_IRQEN    2
`define UIEC_CFG_RESET    8'h00
`define UIEC_CFG_WMASK    8'hFC
// setup packet buffer byte addresses
`define UIEC_SETUP_BASE   16'hFF28
`define UIEC_SETUP_LAST   16'hFF2F
`define UIEC_SETUP_BYTES  8
`endif

// file: design/uiec_pkg.sv
package uiec_pkg;
  typedef enum logic [1:0] {
    UIEC_HS_NONE  = 2'b00,
    UIEC_HS_STALL = 2'b01,
    UIEC_HS_NAK   = 2'b11,
    UIEC_HS_DATA  = 2'b10
  } uiec_answer_e;
  typedef enum logic [1:0] {
    UIEC_PID_DATA0 = 2'b00,
    UIEC_PID_DATA1 = 2'b01
  } uiec_pid_e;
endpackage

// file: design/uiec_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("uiec_fifo: DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_r != rd_ptr_r;
  assign out_data_o  = mem[rd_ptr_r[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_ptr_r <= '0;
    else if (push)
      wr_ptr_r <= wr_ptr_r + 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_ptr_r <= '0;
    else if (pop)
      rd_ptr_r <= rd_ptr_r + 1'b1;
  end
endmodule
`default_nettype wire

// file: design/uiec_in_endpoint.sv
// Notes on behaviour
// RULE1 - software sets bit 7 of the configuration byte to make the in endpoint take part in traffic.
// RULE2 - bit 6 set selects isochronous layout and clear selects control, interrupt or bulk layout.
// RULE3 - outside isochronous mode the toggle bit inverts after each successful data-stage in transaction.
// RULE4 - toggle zero sends DATA0 and toggle one sends DATA1.
// RULE5 - dual buffer set uses both packet buffers in turn, clear uses the first buffer only.
// RULE6 - while stall is set every transaction to the endpoint is answered with STALL.
// RULE7 - the interrupt enable bit lets the endpoint raise its interrupt and otherwise suppresses it.
// RULE8 - in isochronous layout hardware sets the overrun flag on a buffer overflow and only software clears it.
// RULE9 - in isochronous layout bits 4:0 hold bytes per sample minus one.
// RULE10 - the eight data bytes of a setup-stage transaction are kept in a dedicated buffer.
// RULE11 - request type, request code, value, index and length lie at successive setup buffer addresses.
// RULE12 - for isochronous packets the byte length is the sample count times bytes per sample.
// RULE13 - an isochronous endpoint never answers NAK and ignores the buffer-empty flag.
// RULE14 - each two-byte setup field holds its low byte at the lower address.
`include "uiec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uiec_in_endpoint
  import uiec_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // microcontroller byte port
  input  wire logic                cpu_wr_i,
  input  wire logic                cpu_rd_i,
  input  wire logic [15:0]         cpu_addr_i,
  input  wire logic [7:0]          cpu_wdata_i,
  input  wire logic                cfg_sel_i,
  output logic      [7:0]          cpu_rdata_o,
  // buffer state from the microcontroller side
  input  wire logic                buf0_empty_i,
  input  wire logic                buf1_empty_i,
  input  wire logic [6:0]          buf0_count_i,
  input  wire logic [6:0]          buf1_count_i,
  // serial engine requests
  input  wire logic                in_token_i,
  input  wire logic                in_ack_i,
  input  wire logic                overflow_i,
  input  wire logic                setup_valid_i,
  output logic                     setup_ready_o,
  input  wire logic [7:0]          setup_byte_i,
  // answer to the serial engine
  output uiec_pkg::uiec_answer_e   answer_o,
  output uiec_pkg::uiec_pid_e      pid_o,
  output logic                     buf_sel_o,
  output logic      [11:0]         pkt_len_o,
  output logic                     setup_done_o,
  output logic                     irq_o
);
  import uiec_pkg::*;

  initial
  begin
    if (DEPTH != `UIEC_SETUP_BYTES)
      $error("uiec_in_endpoint: setup FIFO depth must equal the packet length");
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]   cfg_r;
  logic [7:0]   setup_mem [`UIEC_SETUP_BYTES];
  logic [2:0]   setup_idx_r;
  logic         cur_buf_r;
  logic         pending_r;
  logic         f_valid;
  logic [7:0]   f_data;
  logic         cfg_wr;
  logic         is_iso;
  logic         active;
  logic         stall;
  logic         sel_empty;
  logic [6:0]   sel_count;
  logic [11:0]  iso_len;
  logic         setup_hit;

  assign cfg_wr    = cpu_wr_i && cfg_sel_i;
  assign is_iso    = cfg_r[`UIEC_BIT_ISO]; // RULE2
  assign active    = cfg_r[`UIEC_BIT_ACTIVE]; // RULE1
  assign stall     = cfg_r[`UIEC_BIT_STALL] && !is_iso;
  assign sel_empty = cur_buf_r ? buf1_empty_i : buf0_empty_i;
  assign sel_count = cur_buf_r ? buf1_count_i : buf0_count_i;
  assign iso_len   = 12'(sel_count) * 12'({1'b0, cfg_r[4:0]} + 6'h01); // RULE12 RULE9
  assign setup_hit = cpu_addr_i >= `UIEC_SETUP_BASE && cpu_addr_i <= `UIEC_SETUP_LAST;

  ////////////////////////////////////////////////////////////////////////
  // configuration byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_r <= `UIEC_CFG_RESET;
    else
    begin
      if (cfg_wr)
        cfg_r <= cpu_wdata_i;
      if (is_iso && overflow_i && active)
        cfg_r[`UIEC_BIT_OVERRUN] <= 1'b1; // RULE8
      else if (!is_iso && in_ack_i && active && !stall && !(cfg_wr && cpu_wdata_i[`UIEC_BIT_ISO]))
        cfg_r[`UIEC_BIT_TOGGLE] <= ~cfg_r[`UIEC_BIT_TOGGLE]; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // packet buffer selection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cur_buf_r <= 1'b0;
    else if (!cfg_r[`UIEC_BIT_DUAL] || is_iso && !cfg_r[`UIEC_BIT_DUAL])
      cur_buf_r <= 1'b0; // RULE5
    else if (in_ack_i && active && !stall)
      cur_buf_r <= ~cur_buf_r; // RULE5
  end

  ////////////////////////////////////////////////////////////////////////
  // token answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      answer_o  <= UIEC_HS_NONE;
      pid_o     <= UIEC_PID_DATA0;
      buf_sel_o <= 1'b0;
      pkt_len_o <= 12'h000;
    end
    else if (in_token_i && active)
    begin
      buf_sel_o <= cur_buf_r;
      pid_o     <= cfg_r[`UIEC_BIT_TOGGLE] && !is_iso ? UIEC_PID_DATA1 : UIEC_PID_DATA0; // RULE4
      pkt_len_o <= is_iso ? iso_len : 12'(sel_count);
      case ({stall, is_iso, sel_empty})
        3'b100, 3'b101: answer_o <= UIEC_HS_STALL; // RULE6
        3'b001:         answer_o <= UIEC_HS_NAK;
        3'b010, 3'b011: answer_o <= UIEC_HS_DATA; // RULE13
        3'b000:         answer_o <= UIEC_HS_DATA;
        default:        answer_o <= UIEC_HS_STALL;
      endcase
    end
    else
      answer_o <= UIEC_HS_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // endpoint interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= in_ack_i && active && !stall && cfg_r[`UIEC_BIT_IRQEN]; // RULE7
  end

  ////////////////////////////////////////////////////////////////////////
  // setup packet capture through the FIFO
  uiec_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_setup_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (setup_valid_i),
    .in_ready_o  (setup_ready_o),
    .in_data_i   (setup_byte_i),
    .out_valid_o (f_valid),
    .out_ready_i (!pending_r),
    .out_data_o  (f_data)
  );

  // bytes land in arrival order, so low bytes of word fields sit lower
  always_ff @(posedge clk_i)
  begin
    if (f_valid && !pending_r)
      setup_mem[setup_idx_r] <= f_data; // RULE10 RULE11 RULE14
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      setup_idx_r <= 3'h0;
    else if (f_valid && !pending_r)
      setup_idx_r <= setup_idx_r + 3'h1;
  end

  // after eight bytes, hold until software reads the last buffer byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_r <= 1'b0;
    else if (f_valid && !pending_r && setup_idx_r == 3'h7)
      pending_r <= 1'b1;
    else if (cpu_rd_i && cpu_addr_i == `UIEC_SETUP_LAST)
      pending_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      setup_done_o <= 1'b0;
    else
      setup_done_o <= f_valid && !pending_r && setup_idx_r == 3'h7;
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cpu_rdata_o <= 8'h00;
    else if (cpu_rd_i && cfg_sel_i)
      cpu_rdata_o <= is_iso ? cfg_r : (cfg_r & `UIEC_CFG_WMASK);
    else if (cpu_rd_i && setup_hit)
      cpu_rdata_o <= setup_mem[cpu_addr_i[2:0]]; // RULE11
    else if (cpu_rd_i)
      cpu_rdata_o <= 8'h00;
  end
endmodule
`default_nettype wire

// file: verif/uiec_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // setup packet source
  input  wire logic        go_i,
  input  wire logic [63:0] pkt_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic      [7:0]  byte_o
);
  int         seed = 71;
  logic [3:0] idx_r;
  // random gaps between bytes; a released line shows the inverse
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_o <= 1'h0;
      idx_r   <= 4'h0;
      byte_o  <= 8'h00;
    end
    else if (valid_o && ready_i)
    begin
      valid_o <= 1'h0;
      byte_o  <= ~byte_o;
      idx_r   <= idx_r + 4'h1;
    end
    else if (!valid_o && go_i && idx_r < 4'h8 && $random(seed) % 2 != 0)
    begin
      valid_o <= 1'h1;
      byte_o  <= pkt_i[idx_r*8 +: 8];
    end
  end
endmodule
`default_nettype wire

// file: verif/uiec_in_endpoint_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_in_endpoint_checker
  import uiec_pkg::*;
(
  // watched ports
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cpu_rd_i,
  input wire logic                  in_token_i,
  input wire logic                  in_ack_i,
  input wire logic                  buf0_empty_i,
  input wire logic                  buf1_empty_i,
  input wire logic [7:0]            cpu_rdata_o,
  input wire uiec_pkg::uiec_answer_e answer_o,
  input wire uiec_pkg::uiec_pid_e   pid_o,
  input wire logic                  buf_sel_o,
  input wire logic [11:0]           pkt_len_o,
  input wire logic                  setup_done_o,
  input wire logic                  irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_answer_cause: assert property (answer_o != UIEC_HS_NONE |-> $past(in_token_i))
    else $error("answer without token");
  a_pid_hold: assert property (!$past(in_token_i) |-> $stable(pid_o))
    else $error("pid moved without token");
  a_len_hold: assert property (!$past(in_token_i) |-> $stable(pkt_len_o))
    else $error("length moved without token");
  a_buf_hold: assert property (!$past(in_token_i) |-> $stable(buf_sel_o))
    else $error("buffer select moved without token");
  a_irq_cause: assert property (irq_o |-> $past(in_ack_i))
    else $error("interrupt without ack");
  a_done_pulse: assert property (setup_done_o |=> !setup_done_o)
    else $error("setup done longer than one cycle");
  a_nak_empty: assert property (answer_o == UIEC_HS_NAK |-> $past(buf0_empty_i || buf1_empty_i))
    else $error("nak with no empty buffer");
  a_rdata_hold: assert property (!$past(cpu_rd_i) |-> $stable(cpu_rdata_o))
    else $error("read data moved without read");
  cover property (answer_o == UIEC_HS_STALL);
  cover property (answer_o == UIEC_HS_NAK);
  cover property (setup_done_o);
endmodule
bind uiec_in_endpoint uiec_in_endpoint_checker u_chk (.clk_i, .rst_i, .cpu_rd_i, .in_token_i, .in_ack_i,
  .buf0_empty_i, .buf1_empty_i, .cpu_rdata_o, .answer_o, .pid_o, .buf_sel_o, .pkt_len_o, .setup_done_o, .irq_o);
`default_nettype wire

// file: verif/uiec_in_endpoint_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_in_endpoint_tb;
  import uiec_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1, cpu_wr_i = 1'h0, cpu_rd_i = 1'h0, cfg_sel_i = 1'h0, go = 1'h0;
  logic        in_token_i = 1'h0, in_ack_i = 1'h0, overflow_i = 1'h0, buf0_empty_i = 1'h0, buf1_empty_i = 1'h0;
  logic        rd_seen = 1'h0, done_seen = 1'h0, setup_valid, setup_ready_o, buf_sel_o, setup_done_o, irq_o;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0]  cpu_wdata_i = 8'h00, cpu_rdata_o, setup_byte;
  logic [6:0]  c0, c1;
  logic [11:0] pkt_len_o;
  logic [16:0] e, qa[$], qr[$];
  logic [63:0] pkt = 64'h0040_0409_0302_0680;
  uiec_answer_e answer_o;
  uiec_pid_e    pid_o;
  int          err_total = 0, samples_checked = 0, irq_n = 0, seed = 71, i;
  always #12.5 clk_i = ~clk_i;
  uiec_in_endpoint uut (.clk_i, .rst_i, .cpu_wr_i, .cpu_rd_i, .cpu_addr_i, .cpu_wdata_i, .cfg_sel_i,
    .cpu_rdata_o, .buf0_empty_i, .buf1_empty_i, .buf0_count_i(c0), .buf1_count_i(c1), .in_token_i, .in_ack_i,
    .overflow_i, .setup_valid_i(setup_valid), .setup_ready_o, .setup_byte_i(setup_byte), .answer_o, .pid_o,
    .buf_sel_o, .pkt_len_o, .setup_done_o, .irq_o);
  uiec_host_model host (.clk_i, .rst_i, .go_i(go), .pkt_i(pkt), .ready_i(setup_ready_o),
    .valid_o(setup_valid), .byte_o(setup_byte));
  ////////////////////////////////////////
  task automatic chk(input logic [16:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // byte port access; a read notes its expected data
  task automatic acc(input logic w, sel, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cpu_wr_i    <= w;
    cpu_rd_i    <= !w;
    cfg_sel_i   <= sel;
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    if (!w) qr.push_back({9'h000, d});
    @(posedge clk_i);
    {cpu_wr_i, cpu_rd_i, cfg_sel_i} <= 3'h0;
  endtask
  // one pulse: 0 token, 1 ack, 2 overflow
  task automatic evt(input int k, input logic [16:0] x);
    @(posedge clk_i);
    in_token_i <= k == 0;
    in_ack_i   <= k == 1;
    overflow_i <= k == 2;
    if (k == 0 && x[16:15] != 2'h0) qa.push_back(x);
    @(posedge clk_i);
    {in_token_i, in_ack_i, overflow_i} <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  always @(posedge clk_i)
  begin
    rd_seen <= cpu_rd_i;
    if (setup_done_o === 1'h1) done_seen <= 1'h1;
    if (irq_o === 1'h1) irq_n++;
    if (rd_seen) chk({9'h000, cpu_rdata_o}, qr.size() ? qr.pop_front() : 'x);
    if (!rst_i && answer_o !== UIEC_HS_NONE)
    begin
      e = qa.size() ? qa.pop_front() : 'x;
      chk(e[16:15] == 2'h2 ? {answer_o, pid_o, buf_sel_o, pkt_len_o} : {answer_o, e[14:0]}, e);
    end
  end
  initial
  begin
    c0 = 7'($random(seed));
    c1 = 7'($random(seed));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1'h0, 1'h1, 16'h0000, 8'h00);
    acc(1'h1, 1'h1, 16'h0000, 8'h9C);
    evt(0, {UIEC_HS_STALL, 15'h0000});
    acc(1'h1, 1'h1, 16'h0000, 8'h94);
    evt(0, {UIEC_HS_DATA, UIEC_PID_DATA0, 1'h0, 5'h00, c0});
    evt(1, 17'h00000);
    evt(0, {UIEC_HS_DATA, UIEC_PID_DATA1, 1'h1, 5'h00, c1});
    acc(1'h0, 1'h1, 16'h0000, 8'hB4);
    acc(1'h1, 1'h1, 16'h0000, 8'h80);
    evt(1, 17'h00000);
    acc(1'h0, 1'h1, 16'h0000, 8'hA0);
    buf0_empty_i <= 1'h1;
    evt(0, {UIEC_HS_NAK, 15'h0000});
    acc(1'h1, 1'h1, 16'h0000, 8'hC3);
    evt(0, {UIEC_HS_DATA, UIEC_PID_DATA0, 1'h0, 12'(c0 * 4)});
    evt(2, 17'h00000);
    evt(1, 17'h00000);
    acc(1'h0, 1'h1, 16'h0000, 8'hE3);
    acc(1'h1, 1'h1, 16'h0000, 8'h40);
    evt(0, 17'h00000);
    go <= 1'h1;
    for (i = 0; i < 300 && !done_seen; i++) @(posedge clk_i);
    acc(1'h1, 1'h0, 16'hFF28, 8'hFF);
    for (i = 0; i < 8; i++) acc(1'h0, 1'h0, 16'hFF28 + 16'(i), pkt[i*8 +: 8]);
    acc(1'h0, 1'h0, 16'hFFB0, 8'h00);
    repeat (4) @(posedge clk_i);
    chk({16'h0000, done_seen}, 17'h00001);
    chk(17'(irq_n), 17'h00001);
    conclude;
  end
  initial
  begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
